// [program_counter_return_stack_tb_top.sv]
// bench for the counter and return stack core
// assumes the decoder model drives evt and the bench owns the register port
module program_counter_return_stack_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import prs_pkg::*;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic por = 1'b1;
  logic ovr = 1'b0;
  logic clk_en = 1'b1;
  prs_evt_s evt;
  prs_bus_s bus = '0;
  logic [7:0] rdata;
  logic [20:0] pc, cfg_base;
  logic blank, full, unf, rst_req;
  logic [4:0] sp;
  int bad_count = 0;
  int n_checks = 0;

  always #12.5 clock = ~clock;

  prs_dec_model dec (.clock(clock), .evt(evt));
  prs_core #(.IMPL_BYTES(65536)) dut (
    .clock(clock), .sys_rst(sys_rst), .por(por), .clk_en(clk_en),
    .overflow_reset_enable(ovr), .evt(evt), .bus(bus), .rdata(rdata),
    .pc(pc), .fetch_blank(blank), .cfg_base(cfg_base),
    .stack_full_flag(full), .stack_underflow_flag(unf),
    .stack_ptr(sp), .stack_rst_req(rst_req));

  task automatic chk(input logic [20:0] seen, input logic [20:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  // strobe for one cycle, idle the next, so no signal is driven twice
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clock);
    bus <= '0;
    #1;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clock);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clock);
    bus <= '0;
    #1;
    chk(21'(rdata), 21'(exp));
  endtask

  task automatic ev(input int k, input logic [20:0] t);
    dec.issue(k, t);
    #1;
  endtask

  task automatic tdone(input string s);
    $display("test %s done", s);
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // whole run needs well under 1000 cycles
  initial begin
    #200000;
    bad_count++;
    end_sim;
  end

  initial begin
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    por <= 1'b0;
    #1;
    chk(pc, RESET_VEC);
    chk(21'(sp), 21'(SP_EMPTY));
    chk(cfg_base, 21'h00fff8);
    chk(21'(blank), 21'h0);
    chk(21'(rst_req), 21'h0);
    tdone("reset");
    wr(ADDR_PC_HIGH_LATCH, 8'h12);
    wr(ADDR_PC_UPPER_LATCH, 8'h03);
    wr(ADDR_PC_LOW, 8'h47);
    chk(pc, 21'h031246);
    ev(7, 21'h0);
    chk(pc, 21'h031248);
    ev(6, 21'h000100);
    chk(pc, 21'h000100);
    rd(ADDR_PC_LOW, 8'h00);
    rd(ADDR_PC_HIGH_LATCH, 8'h01);
    rd(ADDR_PC_UPPER_LATCH, 8'h00);
    rd(3'h7, 8'h00);
    ev(6, 21'h010000);
    @(posedge clock);
    #1;
    chk(21'(blank), 21'h1);
    tdone("counter");
    ev(6, 21'h000100);
    ev(2, 21'h000200);
    chk(pc, 21'h000200);
    chk(21'(sp), 21'h1);
    rd(ADDR_TOS_HIGH, 8'h01);
    ev(0, 21'h0);
    chk(pc, HI_VEC);
    ev(1, 21'h0);
    chk(pc, LO_VEC);
    rd(ADDR_TOS_LOW, 8'h08);
    ev(3, 21'h0);
    chk(pc, HI_VEC);
    ev(3, 21'h0);
    ev(3, 21'h0);
    chk(pc, 21'h000100);
    chk(21'(sp), 21'h0);
    wr(ADDR_TOS_LOW, 8'h55);
    rd(ADDR_TOS_LOW, 8'h00);
    ev(3, 21'h0);
    chk(pc, 21'h0);
    chk(21'(unf), 21'h1);
    rd(ADDR_STACK_PTR, 8'h40);
    wr(ADDR_STACK_PTR, 8'h00);
    rd(ADDR_STACK_PTR, 8'h00);
    tdone("call_return");
    ev(6, 21'h000abc);
    ev(4, 21'h0);
    rd(ADDR_TOS_LOW, 8'hbc);
    wr(ADDR_TOS_LOW, 8'h10);
    ev(4, 21'h0);
    ev(5, 21'h0);
    rd(ADDR_TOS_LOW, 8'h10);
    chk(pc, 21'h000abc);
    wr(ADDR_STACK_PTR, 8'h05);
    rd(ADDR_STACK_PTR, 8'h05);
    tdone("soft_stack");
    // sticky overflow: entry 31 must keep the 31st pushed value, not the overflowing one
    wr(ADDR_STACK_PTR, 8'h00);
    ev(6, 21'h000222);
    for (int i = 0; i < 31; i++) ev(4, 21'h0);
    rd(ADDR_STACK_PTR, 8'h9f);
    ev(6, 21'h000444);
    ev(4, 21'h0);
    rd(ADDR_STACK_PTR, 8'h9f);
    rd(ADDR_TOS_LOW, 8'h22);
    wr(ADDR_STACK_PTR, 8'h00);
    rd(ADDR_STACK_PTR, 8'h00);
    @(posedge clock) ovr <= 1'b1;
    for (int i = 0; i < 30; i++) ev(4, 21'h0);
    ev(4, 21'h0);
    chk(21'(rst_req), 21'h1);
    chk(21'(sp), 21'h0);
    chk(21'(full), 21'h1);
    tdone("overflow");
    // warm reset with the power-on qualifier low keeps the flags
    @(posedge clock) sys_rst <= 1'b1;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    #1;
    chk(pc, RESET_VEC);
    chk(21'(sp), 21'(SP_EMPTY));
    chk(21'(full), 21'h1);
    chk(21'(rst_req), 21'h0);
    rd(ADDR_PC_HIGH_LATCH, 8'h00);
    rd(ADDR_STACK_PTR, 8'h80);
    // a low enable must swallow the step event
    @(posedge clock) clk_en <= 1'b0;
    ev(7, 21'h0);
    chk(pc, RESET_VEC);
    @(posedge clock) clk_en <= 1'b1;
    ev(7, 21'h0);
    chk(pc, PC_STEP);
    tdone("warm_reset");
    end_sim;
  end
endmodule

// [prs_core.sv]
// program counter, holding latches and 31-level return address stack
// assumes decoder events and register strobes come from the same clock
// What this block does
// R01: 21-bit counter; unimplemented space fetches as zero
// R02: every reset loads counter with 0000h
// R03: high interrupt vectors 0008h, low 0018h
// R04: top eight bytes hold configuration words
// R05: configuration bytes ascend, first word lowest
// R06: only low byte direct; upper via latches
// R07: low write loads latches; read copies back
// R08: counter bit zero fixed; steps by two
// R09: call, goto, branch load counter directly
// R10: calls, interrupts push; returns pop; latches untouched
// R11: stack is 31 by 21, 5-bit pointer
// R12: push increments then writes; pop reads then decrements
// R13: pointer resets to zero; zero has no entry
// R14: top-of-stack registers show and modify entry
// R15: pointer readable and writable, values 0-31
// R16: full after 31 pushes; software or por clears
// R17: overflow reset: store, flag, reset, pointer zero
// R18: no overflow reset: pointer sticks at 31
// R19: empty pop: counter zero, underflow flag set
// R20: software push stores current counter
// R21: software pop only decrements pointer
// R22: software masks interrupts around stack access
// R23: pointer zero: top-of-stack reads zero, ignores writes
module prs_core #(
  parameter int unsigned IMPL_BYTES = 65536
) (
  // clock, reset, enable
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic por,
  input wire logic clk_en,
  // configuration strap
  input wire logic overflow_reset_enable,
  // decoder events
  input wire prs_pkg::prs_evt_s evt,
  // register port
  input wire prs_pkg::prs_bus_s bus,
  output logic [7:0] rdata,
  // counter and status
  output logic [20:0] pc,
  output logic fetch_blank,
  output logic [20:0] cfg_base,
  output logic stack_full_flag,
  output logic stack_underflow_flag,
  output logic [4:0] stack_ptr,
  output logic stack_rst_req
);
  import prs_pkg::*;

  localparam logic [20:0] CFG_ADDR = 21'(IMPL_BYTES - CFG_BYTES);

  logic [20:0] pc_r, pc_nxt;
  logic [7:0] lath_r, lath_nxt;
  logic [4:0] latu_r, latu_nxt;
  logic [4:0] sp_r, sp_nxt;
  logic full_r, full_nxt;
  logic unf_r, unf_nxt;
  logic rst_req_r, rst_req_nxt;
  logic blank_r, blank_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic [20:0] cfg_r;
  logic [20:0] stack_mem [1:STK_DEPTH];
  logic stk_we;
  logic [4:0] stk_idx;
  logic [20:0] stk_wdata;
  logic [20:0] tos_val;
  logic do_push;
  logic [20:0] push_pc;
  logic [4:0] sp_inc;
  logic wr_pc_low, rd_pc_low, wr_sp, tos_wr;

  // decode of the register strobes
  assign wr_pc_low = bus.wr && bus.addr == ADDR_PC_LOW;
  assign rd_pc_low = bus.rd && bus.addr == ADDR_PC_LOW;
  assign wr_sp = bus.wr && bus.addr == ADDR_STACK_PTR;
  assign tos_wr = bus.wr && (bus.addr == ADDR_TOS_LOW ||
    bus.addr == ADDR_TOS_HIGH || bus.addr == ADDR_TOS_UPPER);
  assign sp_inc = sp_r + SP_ONE;

  // entry zero has no storage, so the top reads as zero there
  assign tos_val = (sp_r == SP_EMPTY) ? RESET_VEC : stack_mem[sp_r]; // R13 R23

  // counter, latch and stack pointer next state
  always_comb begin
    pc_nxt = pc_r;
    lath_nxt = lath_r;
    latu_nxt = latu_r;
    sp_nxt = sp_r;
    full_nxt = full_r;
    unf_nxt = unf_r;
    rst_req_nxt = 1'b0;
    stk_we = 1'b0;
    stk_idx = sp_inc;
    stk_wdata = pc_r;
    do_push = 1'b0;
    push_pc = pc_r;
    // software clears first, so a same-cycle set event still wins
    if (wr_sp && !bus.wdata[FULL_BIT]) begin
      full_nxt = 1'b0; // R16
    end
    if (wr_sp && !bus.wdata[UNF_BIT]) begin
      unf_nxt = 1'b0; // R19
    end
    // priority: interrupts, call, return, push, pop, jump, step
    if (evt.int_hi || evt.int_lo) begin
      do_push = 1'b1; // R10
      pc_nxt = evt.int_hi ? HI_VEC : LO_VEC; // R03
    end else if (evt.call) begin
      do_push = 1'b1; // R10
      pc_nxt = {evt.target[20:1], 1'b0}; // R09
    end else if (evt.ret) begin
      if (sp_r == SP_EMPTY) begin
        pc_nxt = RESET_VEC; // R19
        unf_nxt = 1'b1; // R19
      end else begin
        pc_nxt = {tos_val[20:1], 1'b0}; // R12
        sp_nxt = sp_r - SP_ONE; // R12
      end
    end else if (evt.sw_push) begin
      do_push = 1'b1; // R20
    end else if (evt.sw_pop) begin
      if (sp_r == SP_EMPTY) begin
        unf_nxt = 1'b1;
      end else begin
        sp_nxt = sp_r - SP_ONE; // R21
      end
    end else if (evt.jump) begin
      pc_nxt = {evt.target[20:1], 1'b0}; // R09
    end else if (evt.step) begin
      pc_nxt = pc_r + PC_STEP; // R08
    end
    // the pushed value is the counter, already past the instruction
    if (do_push) begin
      if (sp_r == SP_TOP) begin
        full_nxt = 1'b1; // R18
      end else begin
        stk_we = 1'b1; // R12
        stk_idx = sp_inc;
        stk_wdata = push_pc;
        sp_nxt = sp_inc;
        if (sp_inc == SP_TOP) begin
          full_nxt = 1'b1; // R16
          if (overflow_reset_enable) begin
            sp_nxt = SP_EMPTY; // R17
            rst_req_nxt = 1'b1; // R17
          end
        end
      end
    end
    // register writes win over same-cycle decoder events, except the flag clears above
    if (wr_pc_low) begin
      pc_nxt = {latu_r, lath_r, bus.wdata[7:1], 1'b0}; // R07 R06
    end
    if (rd_pc_low) begin
      lath_nxt = pc_r[15:8]; // R07
      latu_nxt = pc_r[20:16]; // R07
    end
    if (bus.wr && bus.addr == ADDR_PC_HIGH_LATCH) begin
      lath_nxt = bus.wdata; // R06
    end
    if (bus.wr && bus.addr == ADDR_PC_UPPER_LATCH) begin
      latu_nxt = bus.wdata[4:0]; // R06
    end
    if (wr_sp) begin
      sp_nxt = bus.wdata[4:0]; // R15
    end
    // top-of-stack byte writes patch the selected entry
    if (tos_wr && sp_r != SP_EMPTY) begin
      stk_we = 1'b1; // R14 R23
      stk_idx = sp_r;
      stk_wdata = tos_val;
      unique case (bus.addr)
        ADDR_TOS_LOW: stk_wdata[7:0] = bus.wdata;
        ADDR_TOS_HIGH: stk_wdata[15:8] = bus.wdata;
        default: stk_wdata[20:16] = bus.wdata[4:0];
      endcase
    end
  end

  // read data and fetch qualifier next state
  always_comb begin
    rdata_nxt = RESET_BYTE;
    if (bus.rd) begin
      unique case (bus.addr)
        ADDR_PC_LOW: rdata_nxt = pc_r[7:0]; // R06
        ADDR_PC_HIGH_LATCH: rdata_nxt = lath_r;
        ADDR_PC_UPPER_LATCH: rdata_nxt = {3'h0, latu_r};
        ADDR_STACK_PTR: rdata_nxt = {full_r, unf_r, 1'b0, sp_r}; // R15
        ADDR_TOS_LOW: rdata_nxt = tos_val[7:0]; // R14
        ADDR_TOS_HIGH: rdata_nxt = tos_val[15:8];
        ADDR_TOS_UPPER: rdata_nxt = {3'h0, tos_val[20:16]};
        default: rdata_nxt = RESET_BYTE;
      endcase
    end
    // beyond implemented memory the fetch is forced to an all-zero word
    blank_nxt = 32'(pc_nxt) >= IMPL_BYTES; // R01
  end

  // state registers; reset acts even while the enable is low
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pc_r <= RESET_VEC; // R02
      lath_r <= RESET_BYTE;
      latu_r <= RESET_UPPER;
      sp_r <= SP_EMPTY; // R13
      rst_req_r <= 1'b0;
      blank_r <= 1'b0;
      rdata_r <= RESET_BYTE;
      cfg_r <= CFG_ADDR; // R04 R05
      // stack flags survive all resets except power-on
      if (por) begin
        full_r <= 1'b0; // R16
        unf_r <= 1'b0; // R19
      end
    end else if (clk_en) begin
      pc_r <= pc_nxt;
      lath_r <= lath_nxt;
      latu_r <= latu_nxt;
      sp_r <= sp_nxt;
      full_r <= full_nxt;
      unf_r <= unf_nxt;
      rst_req_r <= rst_req_nxt;
      blank_r <= blank_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // stack storage, outside program and data space; no reset needed
  always_ff @(posedge clock) begin
    if (clk_en && !sys_rst && stk_we) begin
      stack_mem[stk_idx] <= stk_wdata; // R11
    end
  end

  assign pc = pc_r;
  assign rdata = rdata_r;
  assign fetch_blank = blank_r;
  assign cfg_base = cfg_r;
  assign stack_full_flag = full_r;
  assign stack_underflow_flag = unf_r;
  assign stack_ptr = sp_r;
  assign stack_rst_req = rst_req_r;

  // checks
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);

  logic push_only;
  // software push counts too, unless a return outranks it
  assign push_only = clk_en && !bus.wr && (evt.call || evt.int_hi ||
    evt.int_lo || (evt.sw_push && !evt.ret));

  reset_vector_a: assert property (disable iff (1'b0) // R02
    sys_rst |=> pc_r == RESET_VEC && sp_r == SP_EMPTY)
    else $error("reset did not clear counter or pointer");

  int_vector_a: assert property ( // R03
    clk_en && evt.int_hi && !wr_pc_low |=> pc_r == HI_VEC)
    else $error("high interrupt vector wrong");

  pc_lsb_a: assert property (pc_r[0] == 1'b0) // R08
    else $error("counter bit zero set");

  seq_step_a: assert property ( // R08
    clk_en && evt.step && !wr_pc_low && !evt.int_hi && !evt.int_lo &&
    !evt.call && !evt.ret && !evt.jump && !evt.sw_push && !evt.sw_pop
    |=> pc_r == $past(pc_r) + PC_STEP)
    else $error("sequential step not two");

  latch_load_a: assert property ( // R07
    clk_en && wr_pc_low |=>
    pc_r == {$past(latu_r), $past(lath_r), $past(bus.wdata[7:1]), 1'b0})
    else $error("low write did not load latches");

  push_ptr_a: assert property ( // R12
    push_only && sp_r < 5'h1e |=> sp_r == $past(sp_r) + SP_ONE
    && stack_mem[sp_r] == $past(pc_r))
    else $error("push pointer or data wrong");

  empty_pop_a: assert property ( // R19
    clk_en && evt.ret && !evt.call && !evt.int_hi && !evt.int_lo &&
    !bus.wr && sp_r == SP_EMPTY
    |=> pc_r == RESET_VEC && unf_r && sp_r == SP_EMPTY)
    else $error("empty pop mishandled");

  ovf_reset_a: assert property ( // R17
    push_only && overflow_reset_enable && sp_r == 5'h1e
    |=> sp_r == SP_EMPTY && full_r && stack_rst_req)
    else $error("overflow reset not taken");

  ovf_stick_a: assert property ( // R18
    push_only && !overflow_reset_enable && sp_r == SP_TOP
    |=> sp_r == SP_TOP && full_r && !stack_rst_req)
    else $error("pointer left top on overflow");

  tos_zero_a: assert property ( // R23
    clk_en && bus.rd && bus.addr == ADDR_TOS_LOW && sp_r == SP_EMPTY
    |=> rdata == RESET_BYTE)
    else $error("empty top of stack not zero");

  lo_vector_a: assert property ( // R03
    clk_en && evt.int_lo && !evt.int_hi && !wr_pc_low |=> pc_r == LO_VEC)
    else $error("low interrupt vector wrong");

  jump_load_a: assert property ( // R09
    clk_en && evt.jump && !bus.wr && !evt.int_hi && !evt.int_lo &&
    !evt.call && !evt.ret && !evt.sw_push && !evt.sw_pop
    |=> pc_r == {$past(evt.target[20:1]), 1'b0})
    else $error("jump target not loaded");

  pop_ptr_a: assert property ( // R12
    clk_en && evt.ret && !evt.call && !evt.int_hi && !evt.int_lo &&
    !bus.wr && sp_r != SP_EMPTY |=> sp_r == $past(sp_r) - SP_ONE &&
    pc_r == {$past(tos_val[20:1]), 1'b0})
    else $error("pop pointer or counter wrong");

  sw_pop_a: assert property ( // R21
    clk_en && evt.sw_pop && !evt.sw_push && !evt.ret && !evt.call &&
    !evt.int_hi && !evt.int_lo && !bus.wr && sp_r != SP_EMPTY
    |=> sp_r == $past(sp_r) - SP_ONE && pc_r == $past(pc_r))
    else $error("software pop not a bare decrement");

  latch_copy_a: assert property ( // R07
    clk_en && rd_pc_low && !bus.wr |=>
    lath_r == $past(pc_r[15:8]) && latu_r == $past(pc_r[20:16]))
    else $error("low read did not copy counter to latches");

  latch_keep_a: assert property ( // R10
    !bus.wr && !rd_pc_low |=> lath_r == $past(lath_r) &&
    latu_r == $past(latu_r))
    else $error("latches moved without a register access");

  blank_track_a: assert property ( // R01
    fetch_blank == (32'(pc_r) >= IMPL_BYTES))
    else $error("fetch blank out of step with counter");

  full_hold_a: assert property ( // R16
    full_r && !(wr_sp && !bus.wdata[FULL_BIT]) |=> full_r)
    else $error("full flag dropped without a clear");

  unf_hold_a: assert property ( // R19
    unf_r && !(wr_sp && !bus.wdata[UNF_BIT]) |=> unf_r)
    else $error("underflow flag dropped without a clear");

  rst_pulse_a: assert property ( // R17
    stack_rst_req && clk_en |=> !stack_rst_req)
    else $error("overflow reset request longer than a cycle");
endmodule

// [prs_dec_model.sv]
// decoder model: drives one event pulse for each call of issue
// assumes the caller waits for issue to return before calling again
module prs_dec_model (
  // clock
  input wire logic clock,
  // decoder events toward the core
  output prs_pkg::prs_evt_s evt
);
  timeunit 1ns;
  timeprecision 100ps;
  import prs_pkg::*;

  initial evt = '0;

  // k picks the flag: 0 int_hi .. 7 step; flags sit at bits 28 down to 21
  task automatic issue(input int k, input logic [20:0] t);
    prs_evt_s e;
    e = '0;
    e.target = t;
    e[28-k] = 1'b1;
    @(posedge clock);
    // issued only between register accesses, never mid stack update
    evt <= e;
    @(posedge clock);
    evt <= '0; // pulse lasts exactly one cycle
  endtask
endmodule

// [prs_pkg.sv]
// shared constants and carriers for the program counter and return stack
// assumes a single clock domain shared with the instruction decoder
package prs_pkg;
  localparam int PC_W = 21;
  localparam int SP_W = 5;
  localparam int STK_DEPTH = 31;
  localparam int CFG_BYTES = 8;
  localparam logic [20:0] RESET_VEC = 21'h000000;
  localparam logic [20:0] HI_VEC = 21'h000008;
  localparam logic [20:0] LO_VEC = 21'h000018;
  localparam logic [20:0] PC_STEP = 21'h000002;
  localparam logic [4:0] SP_EMPTY = 5'h00;
  localparam logic [4:0] SP_TOP = 5'h1f;
  localparam logic [4:0] SP_ONE = 5'h01;
  // register offsets
  localparam logic [2:0] ADDR_PC_LOW = 3'h0;
  localparam logic [2:0] ADDR_PC_HIGH_LATCH = 3'h1;
  localparam logic [2:0] ADDR_PC_UPPER_LATCH = 3'h2;
  localparam logic [2:0] ADDR_STACK_PTR = 3'h3;
  localparam logic [2:0] ADDR_TOS_LOW = 3'h4;
  localparam logic [2:0] ADDR_TOS_HIGH = 3'h5;
  localparam logic [2:0] ADDR_TOS_UPPER = 3'h6;
  // stack pointer register fields
  localparam int FULL_BIT = 7;
  localparam int UNF_BIT = 6;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [4:0] RESET_UPPER = 5'h00;

  // decoder events, one or more per cycle, resolved by priority
  typedef struct packed {
    logic int_hi;
    logic int_lo;
    logic call;
    logic ret;
    logic sw_push;
    logic sw_pop;
    logic jump;
    logic step;
    logic [20:0] target;
  } prs_evt_s;

  // register port request
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } prs_bus_s;
endpackage
